// >>> scu_uart_defines.svh
/*
 constants of the sensor conditioner serial transceiver: clock rate,
 bit rates, divider counts, receive vote phases, line levels.
 assumes a single 10 MHz core clock.
*/
`ifndef SCU_UART_DEFINES_SVH
`define SCU_UART_DEFINES_SVH

`define SCU_CLK_HZ      10000000
`define SCU_BAUD_SLOW   2400
`define SCU_BAUD_FAST   9600
`define SCU_OVERSAMPLE  16
`define SCU_DIV_SLOW    (`SCU_CLK_HZ / (`SCU_BAUD_SLOW * `SCU_OVERSAMPLE))
`define SCU_DIV_FAST    (`SCU_CLK_HZ / (`SCU_BAUD_FAST * `SCU_OVERSAMPLE))
`define SCU_DIV_W       9
`define SCU_PH_VOTE_A   4'h6
`define SCU_PH_VOTE_B   4'h7
`define SCU_PH_VOTE_C   4'h8
`define SCU_PH_LAST     4'hF
`define SCU_DATA_BITS   8
`define SCU_LAST_BIT    3'h7
`define SCU_LINE_IDLE   1'b1
`define SCU_START_BIT   1'b0
`define SCU_STOP_BIT    1'b1
`define SCU_BUF_DEPTH   2

`endif

// >>> scu_uart_pkg.sv
/*
 types of the sensor conditioner serial transceiver.
 assumes the defines header is compiled alongside.
*/
package scu_uart_pkg;

    typedef enum logic [3:0] {
        SCU_TX_IDLE  = 4'b0001,
        SCU_TX_START = 4'b0010,
        SCU_TX_DATA  = 4'b0100,
        SCU_TX_STOP  = 4'b1000
    } scu_tx_state_t;

    typedef enum logic [3:0] {
        SCU_RX_IDLE  = 4'b0001,
        SCU_RX_START = 4'b0010,
        SCU_RX_DATA  = 4'b0100,
        SCU_RX_STOP  = 4'b1000
    } scu_rx_state_t;

endpackage

// >>> scu_buf_if.sv
/*
 valid/ready carrier between the transmit path and its two-entry buffer.
 assumes both ends share the core clock.
*/
`timescale 1ns/1ps
`include "scu_uart_defines.svh"

interface scu_buf_if;
    logic                      in_valid;
    logic                      in_ready;
    logic [`SCU_DATA_BITS-1:0] in_data;
    logic                      out_valid;
    logic                      out_ready;
    logic [`SCU_DATA_BITS-1:0] out_data;

    modport buf_side (
        input  in_valid,
        input  in_data,
        input  out_ready,
        output in_ready,
        output out_valid,
        output out_data
    );

    modport user_side (
        output in_valid,
        output in_data,
        output out_ready,
        input  in_ready,
        input  out_valid,
        input  out_data
    );
endinterface

// >>> scu_uart_buf.sv
/*
 two-entry buffer for transmit bytes written by the core.
 assumes the drain side stalls while a character is on the line.
*/
`timescale 1ns/1ps
`include "scu_uart_defines.svh"

module scu_uart_buf (
    // clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    // both sides of the buffer
    scu_buf_if.buf_side bus
);

    logic [`SCU_DATA_BITS-1:0] mem [`SCU_BUF_DEPTH];
    logic                      wptr;
    logic                      rptr;
    logic [1:0]                count;
    logic                      push;
    logic                      pop;

    assign bus.in_ready  = (count != 2'h2);
    assign bus.out_valid = (count != 2'h0);
    assign bus.out_data  = mem[rptr];
    assign push          = bus.in_valid & bus.in_ready;
    assign pop           = bus.out_valid & bus.out_ready;

    // storage needs no reset; count guards every read
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wptr] <= bus.in_data;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wptr  <= 1'b0;
            rptr  <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wptr <= ~wptr;
            end
            if (pop) begin
                rptr <= ~rptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule

// >>> scu_uart.sv
/*
 byte serial transceiver of the sensor conditioner, one shared pin.
 assumes a 10 MHz core clock, synchronous pin input and an external
 pull-up that holds the shared pin high while nobody drives it.
*/
// Contract
// (R1) transmit and receive paths run independently and at the same time.
// (R2) a completed byte is held while the next one shifts in.
// (R3) an unread held byte is overwritten by the next completed byte.
// (R4) the bit rate comes from the core clock and a rate boost input.
// (R5) each character is a low start bit, eight data bits, a high stop bit.
// (R6) a core write of a byte alone launches its transmission.
// (R7) the transmit interrupt fires as the stop bit is driven on the line.
// (R8) reception starts on a high to low edge of the idle line.
// (R9) each bit is split into sixteen phases, only the middle ones are used.
// (R10) a bit value is the majority of phases seven, eight and nine.
// (R11) the line is debounced and the start bit value is confirmed.
// (R12) the receive interrupt fires when the stop bit has been captured.
// (R13) transmit and receive share one two-way pin.
// (R14) boost low gives 2400 baud, boost high gives 9600 baud.
// (R15) a start bit that votes high is dropped without an interrupt.
// (R16) the receive phase counter ticks at 16x the bit rate, reset per start.
`timescale 1ns/1ps
`include "scu_uart_defines.svh"

module scu_uart
    import scu_uart_pkg::*;
(
    // clock and reset
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rst,
    // rate select
    input  wire logic                      i_rate_boost_select,
    // core transmit port
    input  wire logic                      i_tx_wr,
    input  wire logic [`SCU_DATA_BITS-1:0] i_tx_data,
    output logic                           o_tx_ready,
    output logic                           o_tx_irq,
    // core receive port
    input  wire logic                      i_rx_read,
    output logic [`SCU_DATA_BITS-1:0]      o_rx_data,
    output logic                           o_rx_valid,
    output logic                           o_rx_irq,
    // shared serial pin
    input  wire logic                      i_serial_io_pin,
    output logic                           o_serial_io_pin,
    output logic                           o_serial_io_pin_oe
);

    scu_buf_if buf_bus ();

    logic [`SCU_DIV_W-1:0]     div_cnt [2];
    logic [1:0]                div_tick;
    logic [1:0]                div_restart;
    logic [`SCU_DIV_W-1:0]     div_top;
    scu_tx_state_t             tx_state;
    logic [3:0]                tx_phase;
    logic [2:0]                tx_bit;
    logic [`SCU_DATA_BITS-1:0] tx_shift;
    logic                      tx_end_bit;
    scu_rx_state_t             rx_state;
    logic [3:0]                rx_phase;
    logic [2:0]                rx_bit;
    logic [`SCU_DATA_BITS-1:0] rx_shift;
    logic                      rx_raw;
    logic                      rx_deb;
    logic                      rx_deb_d;
    logic                      rx_fall;
    logic [1:0]                rx_vote;
    logic                      rx_major;
    logic                      rx_at_vote;
    logic                      rx_end_bit;
    logic                      rx_load;

    // transmit buffer: back-pressure reaches the core via o_tx_ready
    scu_uart_buf u_buf (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .bus        (buf_bus.buf_side)
    );

    assign buf_bus.in_valid  = i_tx_wr;
    assign buf_bus.in_data   = i_tx_data;
    assign o_tx_ready        = buf_bus.in_ready;
    assign buf_bus.out_ready = (tx_state == SCU_TX_IDLE);

    // 16x tick per path; index 0 transmit, 1 receive
    assign div_top = i_rate_boost_select ?                     // [R4] [R14]
                     `SCU_DIV_W'(`SCU_DIV_FAST - 1) :
                     `SCU_DIV_W'(`SCU_DIV_SLOW - 1);
    assign div_restart[0] = (tx_state == SCU_TX_IDLE);
    assign div_restart[1] = rx_fall && (rx_state == SCU_RX_IDLE);   // [R16]

    for (genvar g = 0; g < 2; g++) begin : g_div
        // >= keeps a rate change mid-count from running past the top
        assign div_tick[g] = (div_cnt[g] >= div_top);
        always_ff @(posedge i_core_clk) begin
            if (i_rst || div_restart[g] || div_tick[g]) begin
                div_cnt[g] <= '0;
            end else begin
                div_cnt[g] <= div_cnt[g] + `SCU_DIV_W'(1);
            end
        end
    end

    // transmitter, separate from the receiver [R1]
    assign tx_end_bit = div_tick[0] && (tx_phase == `SCU_PH_LAST);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            tx_state <= SCU_TX_IDLE;
            tx_phase <= 4'h0;
            tx_bit   <= 3'h0;
            tx_shift <= '0;
        end else begin
            if (div_tick[0]) begin
                tx_phase <= tx_phase + 4'h1;
            end
            unique case (tx_state)
                SCU_TX_IDLE: begin
                    tx_phase <= 4'h0;
                    if (buf_bus.out_valid) begin                // [R6]
                        tx_shift <= buf_bus.out_data;
                        tx_bit   <= 3'h0;
                        tx_state <= SCU_TX_START;
                    end
                end
                SCU_TX_START: begin
                    if (tx_end_bit) begin
                        tx_state <= SCU_TX_DATA;
                    end
                end
                SCU_TX_DATA: begin
                    if (tx_end_bit) begin
                        tx_shift <= tx_shift >> 1;
                        tx_bit   <= tx_bit + 3'h1;
                        if (tx_bit == `SCU_LAST_BIT) begin
                            tx_state <= SCU_TX_STOP;
                        end
                    end
                end
                SCU_TX_STOP: begin
                    if (tx_end_bit) begin
                        tx_state <= SCU_TX_IDLE;
                    end
                end
            endcase
        end
    end

    // line level from the next state so pin and interrupt change together
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_serial_io_pin    <= `SCU_LINE_IDLE;
            o_serial_io_pin_oe <= 1'b0;
            o_tx_irq           <= 1'b0;
        end else begin
            o_tx_irq <= 1'b0;
            if (tx_state == SCU_TX_IDLE && buf_bus.out_valid) begin
                o_serial_io_pin    <= `SCU_START_BIT;          // [R5]
                o_serial_io_pin_oe <= 1'b1;                    // [R13]
            end else if (tx_end_bit) begin
                unique case (tx_state)
                    SCU_TX_IDLE: begin
                        o_serial_io_pin_oe <= 1'b0;
                    end
                    SCU_TX_START: begin
                        o_serial_io_pin <= tx_shift[0];
                    end
                    SCU_TX_DATA: begin
                        if (tx_bit == `SCU_LAST_BIT) begin
                            o_serial_io_pin <= `SCU_STOP_BIT;   // [R5]
                            o_tx_irq        <= 1'b1;            // [R7]
                        end else begin
                            o_serial_io_pin <= tx_shift[1];
                        end
                    end
                    SCU_TX_STOP: begin
                        // release the pin; the pull-up keeps it idle
                        o_serial_io_pin_oe <= 1'b0;             // [R13]
                    end
                endcase
            end
        end
    end

    // debounce: a level must stand two clocks before it is believed
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rx_raw   <= `SCU_LINE_IDLE;
            rx_deb   <= `SCU_LINE_IDLE;
            rx_deb_d <= `SCU_LINE_IDLE;
        end else begin
            rx_raw   <= i_serial_io_pin;
            rx_deb_d <= rx_deb;
            if (i_serial_io_pin == rx_raw) begin               // [R11]
                rx_deb <= rx_raw;
            end
        end
    end

    assign rx_fall    = rx_deb_d && !rx_deb;                   // [R8]
    assign rx_at_vote = div_tick[1] && (rx_phase == `SCU_PH_VOTE_C);
    assign rx_end_bit = div_tick[1] && (rx_phase == `SCU_PH_LAST);
    // third vote is the live sample at the decision tick
    assign rx_major   = (rx_vote[0] & rx_vote[1]) |             // [R10]
                        (rx_vote[0] & rx_deb) |
                        (rx_vote[1] & rx_deb);
    assign rx_load    = rx_at_vote && (rx_state == SCU_RX_STOP);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rx_vote <= 2'h0;
        end else if (div_tick[1]) begin
            // phases outside the vote window are never looked at [R9]
            if (rx_phase == `SCU_PH_VOTE_A) begin
                rx_vote[0] <= rx_deb;
            end
            if (rx_phase == `SCU_PH_VOTE_B) begin
                rx_vote[1] <= rx_deb;
            end
        end
    end

    // receiver; it also hears our own transmission on the shared pin
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rx_state <= SCU_RX_IDLE;
            rx_phase <= 4'h0;
            rx_bit   <= 3'h0;
            rx_shift <= '0;
        end else begin
            if (div_tick[1]) begin
                rx_phase <= rx_phase + 4'h1;                   // [R9]
            end
            unique case (rx_state)
                SCU_RX_IDLE: begin
                    if (rx_fall) begin
                        rx_phase <= 4'h0;                      // [R16]
                        rx_bit   <= 3'h0;
                        rx_state <= SCU_RX_START;              // [R8]
                    end
                end
                SCU_RX_START: begin
                    if (rx_at_vote && rx_major) begin
                        rx_state <= SCU_RX_IDLE;               // [R15] [R11]
                    end else if (rx_end_bit) begin
                        rx_state <= SCU_RX_DATA;
                    end
                end
                SCU_RX_DATA: begin
                    if (rx_at_vote) begin
                        rx_shift <= {rx_major, rx_shift[7:1]};   // [R10]
                    end
                    if (rx_end_bit) begin
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == `SCU_LAST_BIT) begin
                            rx_state <= SCU_RX_STOP;           // [R5]
                        end
                    end
                end
                SCU_RX_STOP: begin
                    // leave at mid stop so the next start edge is seen
                    if (rx_at_vote) begin
                        rx_state <= SCU_RX_IDLE;
                    end
                end
            endcase
        end
    end

    // holding register; shifting goes on while it holds [R2]
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_rx_data  <= '0;
            o_rx_valid <= 1'b0;
            o_rx_irq   <= 1'b0;
        end else begin
            o_rx_irq <= rx_load;                               // [R12]
            if (rx_load) begin
                o_rx_data  <= rx_shift;                        // [R3]
                o_rx_valid <= 1'b1;
            end else if (i_rx_read) begin
                o_rx_valid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_tx_write;
        i_tx_wr && o_tx_ready && !buf_bus.out_valid &&
        tx_state == SCU_TX_IDLE;
    endsequence

    sequence s_rx_start_seen;
        rx_fall && rx_state == SCU_RX_IDLE;
    endsequence

    property p_tx_launch;
        s_tx_write |=> ##1 tx_state == SCU_TX_START && !o_serial_io_pin;
    endproperty
    a_tx_launch: assert property (p_tx_launch) // [R6]
        else $error("write did not launch a character");

    property p_tx_irq_stop;
        o_tx_irq |-> o_serial_io_pin && o_serial_io_pin_oe &&
                     tx_state == SCU_TX_STOP &&
                     $past(o_serial_io_pin_oe) == 1'b1;
    endproperty
    a_tx_irq_stop: assert property (p_tx_irq_stop) // [R7]
        else $error("transmit interrupt not at stop bit");

    property p_tx_start_low;
        tx_state == SCU_TX_START |-> !o_serial_io_pin && o_serial_io_pin_oe;
    endproperty
    a_tx_start_low: assert property (p_tx_start_low) // [R5]
        else $error("start bit not driven low");

    property p_rx_restart;
        s_rx_start_seen |=> rx_state == SCU_RX_START && div_cnt[1] == '0 &&
                            rx_phase == 4'h0;
    endproperty
    a_rx_restart: assert property (p_rx_restart) // [R16]
        else $error("receive phase not restarted at start edge");

    property p_full_duplex;
        s_rx_start_seen and (tx_state != SCU_TX_IDLE)
            |=> rx_state == SCU_RX_START;
    endproperty
    a_full_duplex: assert property (p_full_duplex) // [R1]
        else $error("receiver blocked by transmitter");

    property p_start_abandon;
        rx_state == SCU_RX_START && rx_at_vote && rx_major
            |=> rx_state == SCU_RX_IDLE ##1 !o_rx_irq;
    endproperty
    a_start_abandon: assert property (p_start_abandon) // [R15]
        else $error("high start bit not abandoned");

    property p_rx_irq_data;
        rx_load |=> o_rx_irq && o_rx_valid &&
                    o_rx_data == $past(rx_shift);
    endproperty
    a_rx_irq_data: assert property (p_rx_irq_data) // [R12]
        else $error("receive interrupt without the captured byte");

    property p_overwrite;
        o_rx_valid && !i_rx_read && rx_load
            |=> o_rx_valid && o_rx_data == $past(rx_shift);
    endproperty
    a_overwrite: assert property (p_overwrite) // [R3]
        else $error("held byte not replaced by newer byte");

    property p_fast_rate;
        div_tick[0] && i_rate_boost_select |=> !div_tick[0] [*8];
    endproperty
    a_fast_rate: assert property (p_fast_rate) // [R4]
        else $error("transmit tick too frequent");

endmodule

// >>> scu_host_model.sv
/*
 partner model: the programming adapter on the shared serial pin.
 assumes an external pull-up, so a released line reads high.
*/
`timescale 1ns/1ps
`include "scu_uart_defines.svh"

module scu_host_model (
    // clock and rate
    input  wire logic  i_core_clk,
    input  wire logic  i_rate_boost_select,
    // shared line
    input  wire logic  i_line,
    output logic       o_line,
    // decoded characters
    output logic       o_got_valid,
    output logic [7:0] o_got_data,
    output logic       o_frame_err
);
    int   bit_clks;
    int   i;
    logic prev_line;
    logic sending;

    // same integer tick divider as the device, so no drift
    assign bit_clks = `SCU_OVERSAMPLE * (i_rate_boost_select ?
                      `SCU_DIV_FAST : `SCU_DIV_SLOW);

    initial begin
        o_line      = 1'b1;
        o_got_valid = 1'b0;
        o_got_data  = 8'h00;
        o_frame_err = 1'b0;
        prev_line   = 1'b1;
        sending     = 1'b0;
    end

    // only ever pulls low; high means released to the pull-up
    task automatic drive(input logic b, input int n);
        o_line <= b;
        repeat (n) @(posedge i_core_clk);
    endtask

    // start low, eight data bits lsb first, stop high
    task automatic send_byte(input logic [7:0] d);
        @(posedge i_core_clk);
        sending = 1'b1;
        drive(1'b0, bit_clks);
        for (int k = 0; k < 8; k++) begin
            drive(d[k], bit_clks);
        end
        drive(1'b1, bit_clks);
        sending = 1'b0;
    endtask

    // low pulse of n clocks, then quiet for two bit times
    task automatic pulse_low(input int n);
        @(posedge i_core_clk);
        sending = 1'b1;
        drive(1'b0, n);
        drive(1'b1, 2 * bit_clks);
        sending = 1'b0;
    endtask

    // listener samples mid bit; its own frames are ignored
    always begin
        @(posedge i_core_clk);
        o_got_valid <= 1'b0;
        if (!sending && prev_line === 1'b1 && i_line === 1'b0) begin
            repeat (bit_clks / 2) @(posedge i_core_clk);
            for (i = 0; i < 8; i++) begin
                repeat (bit_clks) @(posedge i_core_clk);
                o_got_data[i] <= i_line;
            end
            repeat (bit_clks) @(posedge i_core_clk);
            o_frame_err <= (i_line !== 1'b1);
            o_got_valid <= 1'b1;
        end
        prev_line = i_line;
    end
endmodule

// >>> test_sensor_conditioner_uart.sv
/*
 self-checking bench of the serial transceiver with adapter model.
 models the external pull-up on the pin; the bench resolves the wire.
*/
`timescale 1ns/1ps
`include "scu_uart_defines.svh"

module test_sensor_conditioner_uart;
    logic       i_core_clk = 1'b0;
    logic       i_rst;
    logic       i_rate_boost_select;
    logic       i_tx_wr;
    logic [7:0] i_tx_data;
    logic       i_rx_read;
    wire logic  o_tx_ready;
    wire logic  o_tx_irq;
    wire logic  [7:0] o_rx_data;
    wire logic  o_rx_valid;
    wire logic  o_rx_irq;
    wire logic  o_serial_io_pin;
    wire logic  o_serial_io_pin_oe;
    wire logic  line;
    wire logic  host_line;
    wire logic  got_valid;
    wire logic  [7:0] got_data;
    wire logic  frame_err;
    int         err_count;
    int         num_checks;
    int         tx_irqs = 0;
    int         seed = 32'h54d8;
    logic [7:0] exp_line[$];
    logic [7:0] exp_rx[$];
    logic [7:0] b;
    logic [7:0] b2;

    always #50 i_core_clk = ~i_core_clk;

    assign line = ((o_serial_io_pin_oe === 1'b1) ? o_serial_io_pin : 1'b1)
                  & host_line;

    scu_uart dut (
        .i_core_clk         (i_core_clk),
        .i_rst              (i_rst),
        .i_rate_boost_select(i_rate_boost_select),
        .i_tx_wr            (i_tx_wr),
        .i_tx_data          (i_tx_data),
        .o_tx_ready         (o_tx_ready),
        .o_tx_irq           (o_tx_irq),
        .i_rx_read          (i_rx_read),
        .o_rx_data          (o_rx_data),
        .o_rx_valid         (o_rx_valid),
        .o_rx_irq           (o_rx_irq),
        .i_serial_io_pin    (line),
        .o_serial_io_pin    (o_serial_io_pin),
        .o_serial_io_pin_oe (o_serial_io_pin_oe)
    );

    scu_host_model host (
        .i_core_clk         (i_core_clk),
        .i_rate_boost_select(i_rate_boost_select),
        .i_line             (line),
        .o_line             (host_line),
        .o_got_valid        (got_valid),
        .o_got_data         (got_data),
        .o_frame_err        (frame_err)
    );

    task automatic fail(input string what);
        err_count++;
        $display("unexpected at %0t ns: %s", $time, what);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] want,
                       input string what);
        num_checks++;
        if (got !== want) begin
            fail(what);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // waits for room, then one write pulse; the echo comes back too
    task automatic tx_write(input logic [7:0] d);
        int n;
        n = 0;
        @(negedge i_core_clk);
        while (o_tx_ready !== 1'b1 && n < 60000) begin
            @(negedge i_core_clk);
            n++;
        end
        if (n >= 60000) begin
            fail("ready never came");
            print_verdict();
        end else begin
            @(posedge i_core_clk);
            i_tx_wr   <= 1'b1;
            i_tx_data <= d;
            exp_line.push_back(d);
            exp_rx.push_back(d);
            @(posedge i_core_clk);
            i_tx_wr <= 1'b0;
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (exp_line.size() + exp_rx.size() != 0 && n < 60000) begin
            @(negedge i_core_clk);
            n++;
        end
        if (n >= 60000) begin
            fail("traffic never finished");
            print_verdict();
        end else begin
            repeat (20) @(negedge i_core_clk);
        end
    endtask

    // monitor: each received or line byte takes the oldest note off its queue; transmit pulses are counted
    always @(negedge i_core_clk) begin
        if (o_rx_irq === 1'b1) begin
            if (exp_rx.size() == 0) begin
                fail("receive with nothing pending");
            end else begin
                chk(o_rx_data, exp_rx.pop_front(), "received byte");
            end
            chk(o_rx_valid, 1'b1, "valid with receive pulse");
        end
        if (got_valid === 1'b1) begin
            if (exp_line.size() == 0) begin
                fail("character sent unasked");
            end else begin
                chk(got_data, exp_line.pop_front(), "line byte");
            end
            chk(frame_err, 1'b0, "stop level");
        end
        if (o_tx_irq === 1'b1) begin
            tx_irqs++;
            chk(line, 1'b1, "stop bit on line");
            chk(o_serial_io_pin_oe, 1'b1, "stop bit driven");
        end
    end

    initial begin
        i_rst               = 1'b1;
        i_rate_boost_select = 1'b1;
        i_tx_wr             = 1'b0;
        i_tx_data           = 8'h00;
        i_rx_read           = 1'b0;
        err_count           = 0;
        num_checks          = 0;
        repeat (12) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(negedge i_core_clk);
        chk(o_tx_ready, 1'b1, "ready after reset");
        chk(o_rx_valid, 1'b0, "valid after reset");
        chk(o_rx_data, 8'h00, "data after reset");
        chk(o_serial_io_pin_oe, 1'b0, "pin released");
        // slow rate: one byte out, echoed in
        @(posedge i_core_clk);
        i_rate_boost_select <= 1'b0;
        b = 8'($random(seed));
        tx_write(b);
        wait_idle();
        @(posedge i_core_clk);
        i_rate_boost_select <= 1'b1;
        // fill the buffer until it refuses
        repeat (3) begin
            b = 8'($random(seed));
            tx_write(b);
        end
        @(negedge i_core_clk);
        chk(o_tx_ready, 1'b0, "buffer full");
        @(posedge i_core_clk);
        i_tx_wr   <= 1'b1;
        i_tx_data <= 8'hFF;
        @(posedge i_core_clk);
        i_tx_wr <= 1'b0;
        wait_idle();
        // two bytes in without a read: the newer one wins
        b  = 8'($random(seed));
        b2 = ~b;
        exp_rx.push_back(b);
        host.send_byte(b);
        chk(o_rx_data, b, "held byte");
        exp_rx.push_back(b2);
        host.send_byte(b2);
        chk(o_rx_data, b2, "newer byte kept");
        chk(o_rx_valid, 1'b1, "still full");
        wait_idle();
        @(posedge i_core_clk);
        i_rx_read <= 1'b1;
        @(posedge i_core_clk);
        i_rx_read <= 1'b0;
        @(negedge i_core_clk);
        chk(o_rx_valid, 1'b0, "read empties holder");
        // spike and a start bit that votes high are both dropped
        host.pulse_low(1);
        host.pulse_low(3 * `SCU_DIV_FAST);
        repeat (20) @(negedge i_core_clk);
        chk(o_rx_valid, 1'b0, "no byte from false start");
        // one pulse per character sent: the slow one and three fast ones
        chk(8'(tx_irqs), 8'h04, "transmit interrupts");
        chk(o_serial_io_pin_oe, 1'b0, "pin released when idle");
        print_verdict();
    end
endmodule
